// ### verification/core_model.sv
// Behavioural core issuing I/O accesses and bit operations
`timescale 1ns/1ns
module core_model (
    // Clock
    input wire clk_sys,
    // Requests
    output reg [6:0] addr,
    output reg io_space,
    output reg wr_en,
    output reg rd_en,
    output reg [7:0] wdata,
    output reg bit_op_en,
    output reg [1:0] bit_op,
    output reg [2:0] bit_sel,
    // Answers
    input wire [7:0] rd_data_r,
    input wire rd_valid_r,
    input wire skip_r,
    input wire skip_valid_r,
    input wire op_refused_r
);
    reg [7:0] q_data;
    reg q_valid, q_skip, q_sv, q_ref;
    initial begin
        {addr, io_space, wr_en, rd_en, wdata, bit_op_en, bit_op} = 21'h0;
        bit_sel = 3'h0;
    end
    // Request held over one rising edge, answer taken a cycle later
    task acc(input [6:0] a, input s, w, r, input [7:0] d, input e,
        input [1:0] o, input [2:0] b);
        begin
            @(negedge clk_sys);
            {addr, io_space, wdata, bit_op, bit_sel} = {a, s, d, o, b};
            wr_en = w && a[4:2] != 3'h7;
            rd_en = r;
            bit_op_en = e;
            @(negedge clk_sys);
            {q_data, q_valid, q_skip, q_sv, q_ref} = {rd_data_r,
                rd_valid_r, skip_r, skip_valid_r, op_refused_r};
            {wr_en, rd_en, bit_op_en} = 3'h0;
            wdata = ~d;
        end
    endtask
endmodule // core_model

// ### verification/io_register_space_sva.sv
// Checker for the I/O register space core port
`timescale 1ns/1ns
`include "io_bit_access_consts.vh"
module io_register_space_sva (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Core port
    input wire [6:0] addr,
    input wire io_space,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] wdata,
    input wire bit_op_en,
    input wire [1:0] bit_op,
    input wire [2:0] bit_sel,
    input wire [7:0] rd_data_r,
    input wire rd_valid_r,
    input wire skip_r,
    input wire skip_valid_r,
    input wire op_refused_r,
    // Flags and image
    input wire conv_flag_set,
    input wire [8*`IO_SLOTS-1:0] reg_image
);
    reg [7:0] img_q;
    reg sel_q;
    wire op_s = bit_op_en && io_space && addr == 7'h0A && !wr_en;
    wire w_06 = wr_en && io_space && addr == 7'h06;
    always @(posedge clk_sys) begin
        img_q <= reg_image[87:80];
        sel_q <= reg_image[{5'h0A, bit_sel}];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_high_refused: assert property (bit_op_en && io_space &&
        addr > `IO_BIT_LAST |=> op_refused_r) else $error("not refused");
    a_low_accepted: assert property (op_s |=> !op_refused_r)
        else $error("bit op refused in range");
    a_skip_set: assert property (op_s && bit_op == `OP_SKIP_IF_SET
        |=> skip_valid_r && skip_r == sel_q) else $error("skip set wrong");
    a_skip_clear: assert property (op_s && bit_op == `OP_SKIP_IF_CLEAR
        |=> skip_valid_r && skip_r == !sel_q) else $error("skip clr wrong");
    a_set_only: assert property (op_s && bit_op == `OP_SET_BIT |=>
        reg_image[87:80] == (img_q | 8'h01 << $past(bit_sel)))
        else $error("set bit wrong");
    a_clear_only: assert property (op_s && bit_op == `OP_CLEAR_BIT |=>
        reg_image[87:80] == (img_q & ~(8'h01 << $past(bit_sel))))
        else $error("clear bit wrong");
    a_flag_cleared: assert property (w_06 && wdata[4] && !conv_flag_set
        |=> !reg_image[52]) else $error("flag not cleared");
    a_flag_kept: assert property (w_06 && !wdata[4] && reg_image[52]
        |=> reg_image[52]) else $error("flag lost");
    a_alias_read: assert property (rd_en && !io_space && addr == 7'h2A
        |=> rd_valid_r && rd_data_r == img_q) else $error("alias wrong");
endmodule // io_register_space_sva
bind io_register_space io_register_space_sva u_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .io_space(io_space),
    .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .bit_op_en(bit_op_en),
    .bit_op(bit_op), .bit_sel(bit_sel), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .skip_r(skip_r), .skip_valid_r(skip_valid_r),
    .op_refused_r(op_refused_r), .conv_flag_set(conv_flag_set),
    .reg_image(reg_image));

// ### verification/io_register_space_tb_top.sv
// Self-checking bench for the I/O register space
`timescale 1ns/1ns
`include "io_bit_access_consts.vh"
module io_register_space_bit_access_tb_top;
    reg clk_sys, rst_n, conv_flag_set;
    reg [7:0] pins;
    integer err_total, checks_done;
    integer cyc = 0;
    wire [6:0] addr;
    wire [7:0] wdata, rd_data_r;
    wire [1:0] bit_op;
    wire [2:0] bit_sel;
    wire io_space, wr_en, rd_en, bit_op_en;
    wire rd_valid_r, skip_r, skip_valid_r, op_refused_r;
    wire [8*`IO_SLOTS-1:0] reg_image;
    io_register_space DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .io_space(io_space),
        .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .bit_op_en(bit_op_en),
        .bit_op(bit_op), .bit_sel(bit_sel), .rd_data_r(rd_data_r),
        .rd_valid_r(rd_valid_r), .skip_r(skip_r), .skip_valid_r(skip_valid_r),
        .op_refused_r(op_refused_r), .conv_flag_set(conv_flag_set),
        .cmp_flag_set(conv_flag_set), .ser_flag_set({3{conv_flag_set}}),
        .conv_result_lo(8'h00), .conv_result_hi(8'h00), .ser_buffer_in(8'h00),
        .cmp_out(1'b0), .ser_collision(1'b0), .port_a_pins(pins),
        .port_b_pins(~pins), .reg_image(reg_image));
    core_model u_core (
        .clk_sys(clk_sys), .addr(addr), .io_space(io_space), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata), .bit_op_en(bit_op_en), .bit_op(bit_op),
        .bit_sel(bit_sel), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .skip_r(skip_r), .skip_valid_r(skip_valid_r),
        .op_refused_r(op_refused_r));
    ////////////////////////////////////////////////////////////////////////
    task chk(input [7:0] seen, exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task print_verdict;
        begin
            if (err_total == 0 && checks_done > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task wr(input [6:0] a, input s, input [7:0] d);
        u_core.acc(a, s, 1'b1, 1'b0, d, 1'b0, 2'h0, 3'h0);
    endtask
    task rd(input [6:0] a, input s, input [7:0] e);
        begin
            u_core.acc(a, s, 1'b0, 1'b1, 8'h00, 1'b0, 2'h0, 3'h0);
            chk(u_core.q_data & {8{u_core.q_valid}}, e);
        end
    endtask
    task bop(input [6:0] a, input s, input [1:0] o, input [2:0] b);
        u_core.acc(a, s, 1'b0, 1'b0, 8'h00, 1'b1, o, b);
    endtask
    task skp(input [1:0] o, input [2:0] b, input [7:0] e);
        begin
            bop(7'h0A, 1'b1, o, b);
            chk({5'h00, u_core.q_ref, u_core.q_sv, u_core.q_skip}, e);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_alias;
        begin
            wr(7'h0A, 1'b1, 8'h55);
            rd(7'h2A, 1'b0, 8'h55);
            wr(7'h2B, 1'b0, 8'hA3);
            rd(7'h0B, 1'b1, 8'hA3);
            wr(7'h00, 1'b1, 8'h3F);
            rd(7'h20, 1'b0, 8'h3F);
            rd(7'h39, 1'b0, 8'hA5);
        end
    endtask
    task t_bits;
        begin
            bop(7'h0A, 1'b1, `OP_SET_BIT, 3'h3);
            bop(7'h0A, 1'b1, `OP_CLEAR_BIT, 3'h0);
            rd(7'h0A, 1'b1, 8'h5C);
            skp(`OP_SKIP_IF_SET, 3'h3, 8'h03);
            skp(`OP_SKIP_IF_SET, 3'h1, 8'h02);
            skp(`OP_SKIP_IF_CLEAR, 3'h1, 8'h03);
            skp(`OP_SKIP_IF_CLEAR, 3'h3, 8'h02);
            bop(7'h1B, 1'b1, `OP_SET_BIT, 3'h7);
            chk({7'h00, u_core.q_ref}, 8'h00);
            rd(7'h1B, 1'b1, 8'h80);
        end
    endtask
    task t_w1c;
        begin
            @(negedge clk_sys);
            conv_flag_set = 1'b1;
            @(negedge clk_sys);
            conv_flag_set = 1'b0;
            bop(7'h06, 1'b1, `OP_SET_BIT, 3'h0);
            rd(7'h06, 1'b1, 8'h11);
            wr(7'h06, 1'b1, 8'h01);
            rd(7'h06, 1'b1, 8'h11);
            wr(7'h06, 1'b1, 8'h11);
            rd(7'h06, 1'b1, 8'h01);
        end
    endtask
    task t_refuse;
        begin
            bop(7'h2A, 1'b0, `OP_SET_BIT, 3'h1);
            chk({7'h00, u_core.q_ref}, 8'h01);
            bop(7'h3A, 1'b1, `OP_CLEAR_BIT, 3'h2);
            chk({7'h00, u_core.q_ref}, 8'h01);
            rd(7'h0A, 1'b1, 8'h5C);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        conv_flag_set = 1'b0;
        pins = 8'hA5;
        err_total = 0;
        checks_done = 0;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        t_alias;
        t_bits;
        t_w1c;
        t_refuse;
        print_verdict;
    end
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            err_total = err_total + 1;
            print_verdict;
        end
    end
endmodule // io_register_space_bit_access_tb_top

// ### verilog/io_addr_decode.v
// Address decoder for I/O and data space views of the register space
`timescale 1ns/1ns
`include "io_bit_access_consts.vh"

module io_addr_decode (
    // Access address
    input wire [6:0] addr,
    input wire io_space,
    // Decoded slot
    output reg hit,
    output reg [4:0] idx,
    output reg bit_ok
);

    reg [6:0] base;

    always @* begin
        // Data space view sits above the I/O view by a fixed offset
        if (io_space) begin
            base = addr;
        end else begin
            base = addr - `IO_DATA_OFFSET; // RL7
        end
        hit = (addr >= (io_space ? 7'h00 : `IO_DATA_OFFSET)) &&
              (base <= `IO_BIT_LAST); // RL7
        idx = base[4:0];
        // Bit operations exist only in the I/O view of the low range
        bit_ok = io_space && (addr <= `IO_BIT_LAST); // RL1
    end

endmodule // io_addr_decode

// ### verilog/io_bit_access_consts.vh
// Constants for the lower I/O register space with single-bit access
// Behaviour
// RL1 - Bit set/clear only at I/O 0x00-0x1F
// RL2 - Skip on selected bit set or clear
// RL3 - Writing one clears status flag; zero keeps
// RL4 - Bit operation touches only addressed bit
// RL5 - Software writes zero to reserved bits
// RL6 - Software never writes reserved I/O addresses
// RL7 - Data space alias at I/O plus 0x20
`ifndef IO_BIT_ACCESS_CONSTS_VH
`define IO_BIT_ACCESS_CONSTS_VH

// Address space
`define IO_BIT_LAST 7'h1F
`define IO_DATA_OFFSET 7'h20
`define IO_SLOTS 32
`define IO_LAST_IMPL 5'h1B

// Register indices
`define IDX_T1_OUT_EN 5'h00
`define IDX_CONV_DIS_LO 5'h01
`define IDX_CONV_DIS_HI 5'h02
`define IDX_CONV_CTRL_B 5'h03
`define IDX_CONV_RES_LO 5'h04
`define IDX_CONV_RES_HI 5'h05
`define IDX_CONV_CSR_A 5'h06
`define IDX_CONV_SEL 5'h07
`define IDX_CMP_CSR_A 5'h08
`define IDX_CMP_CTRL_B 5'h09
`define IDX_SCRATCH_0 5'h0A
`define IDX_SCRATCH_1 5'h0B
`define IDX_SCRATCH_2 5'h0C
`define IDX_SER_CTRL 5'h0D
`define IDX_SER_STATUS 5'h0E
`define IDX_SER_SHIFT 5'h0F
`define IDX_SER_BUF 5'h10
`define IDX_SER_PIN_POS 5'h11
`define IDX_T0_CMP_B 5'h12
`define IDX_T0_CMP_A 5'h13
`define IDX_T0_CNT_HI 5'h14
`define IDX_T0_CTRL_A 5'h15
`define IDX_PB_PIN 5'h16
`define IDX_PB_DIR 5'h17
`define IDX_PB_OUT 5'h18
`define IDX_PA_PIN 5'h19
`define IDX_PA_DIR 5'h1A
`define IDX_PA_OUT 5'h1B

// Writable bit masks (reserved and read-only bits are zero)
`define MASK_ALL 8'hFF
`define MASK_NONE 8'h00
`define MASK_T1_OUT_EN 8'h3F
`define MASK_CONV_DIS_HI 8'hF0
`define MASK_CONV_CTRL_B 8'hDF
`define MASK_CONV_CSR_A 8'hEF
`define MASK_CMP_CSR_A 8'hCF
`define MASK_CMP_CTRL_B 8'hC7
`define MASK_SER_STATUS 8'h0F
`define MASK_SER_PIN_POS 8'h01
`define MASK_T0_CTRL_A 8'hF9

// Write-one-to-clear flag masks
`define W1C_CONV_CSR_A 8'h10
`define W1C_CMP_CSR_A 8'h10
`define W1C_SER_STATUS 8'hE0

// Hardware driven read-only and write-one-to-clear flag bits inside mixed registers
`define RO_CMP_OUT_BIT 5
`define RO_SER_COLL_BIT 4
`define FLAG_CONV_BIT 4
`define FLAG_CMP_BIT 4

// Reset value of every stored register
`define IO_RESET_VALUE 8'h00

// Bit operation codes
`define OP_SET_BIT 2'h0
`define OP_CLEAR_BIT 2'h1
`define OP_SKIP_IF_SET 2'h2
`define OP_SKIP_IF_CLEAR 2'h3

`endif

// ### verilog/io_register_space.v
// Lower I/O register space with byte, single-bit and skip-test access
`timescale 1ns/1ns
`include "io_bit_access_consts.vh"

module io_register_space (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Core access port
    input wire [6:0] addr,
    input wire io_space,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] wdata,
    // Core bit operation port
    input wire bit_op_en,
    input wire [1:0] bit_op,
    input wire [2:0] bit_sel,
    // Answers to the core
    output reg [7:0] rd_data_r,
    output reg rd_valid_r,
    output reg skip_r,
    output reg skip_valid_r,
    output reg op_refused_r,
    // Peripheral flag events
    input wire conv_flag_set,
    input wire cmp_flag_set,
    input wire [2:0] ser_flag_set,
    // Peripheral read-only values
    input wire [7:0] conv_result_lo,
    input wire [7:0] conv_result_hi,
    input wire [7:0] ser_buffer_in,
    input wire cmp_out,
    input wire ser_collision,
    input wire [7:0] port_a_pins,
    input wire [7:0] port_b_pins,
    // Stored register image toward peripherals
    output wire [8*`IO_SLOTS-1:0] reg_image
);

    ////////////////////////////////////////////////////////////////////////
    // Storage and decode

    reg [8*`IO_SLOTS-1:0] regs_r;
    reg [8*`IO_SLOTS-1:0] regs_nxt;
    wire dec_hit;
    wire [4:0] dec_idx;
    wire dec_bit_ok;
    reg acc_en;
    reg [7:0] acc_mask;
    reg [7:0] acc_data;
    reg [7:0] rd_val;
    reg [5:0] k;
    reg [7:0] old_v;
    reg [7:0] new_v;
    reg [7:0] wm;
    reg [7:0] rw_m;
    reg [7:0] w1c_m;
    reg [7:0] set_m;
    wire is_skip;
    wire do_write;
    wire do_bit;
    wire do_skip;
    wire do_read;
    wire bit_refused;

    assign reg_image = regs_r;
    assign is_skip = (bit_op == `OP_SKIP_IF_SET) ||
                     (bit_op == `OP_SKIP_IF_CLEAR);

    ////////////////////////////////////////////////////////////////////////
    // Request classes

    // Byte writes win over a set or clear bit operation
    assign do_write = wr_en && dec_hit;
    assign do_bit = bit_op_en && !is_skip && dec_bit_ok; // RL1
    assign do_skip = bit_op_en && is_skip && dec_bit_ok; // RL2
    assign do_read = rd_en && dec_hit; // RL7
    assign bit_refused = bit_op_en && !dec_bit_ok; // RL1

    io_addr_decode u_decode (
        .addr(addr),
        .io_space(io_space),
        .hit(dec_hit),
        .idx(dec_idx),
        .bit_ok(dec_bit_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // Per-register bit classes

    // Bits that byte and bit writes may store
    function [7:0] rw_mask;
        input [4:0] i;
        begin
            case (i)
                `IDX_T1_OUT_EN: rw_mask = `MASK_T1_OUT_EN;
                `IDX_CONV_DIS_HI: rw_mask = `MASK_CONV_DIS_HI;
                `IDX_CONV_CTRL_B: rw_mask = `MASK_CONV_CTRL_B;
                `IDX_CONV_CSR_A: rw_mask = `MASK_CONV_CSR_A;
                `IDX_CMP_CSR_A: rw_mask = `MASK_CMP_CSR_A;
                `IDX_CMP_CTRL_B: rw_mask = `MASK_CMP_CTRL_B;
                `IDX_SER_STATUS: rw_mask = `MASK_SER_STATUS;
                `IDX_SER_PIN_POS: rw_mask = `MASK_SER_PIN_POS;
                `IDX_T0_CTRL_A: rw_mask = `MASK_T0_CTRL_A;
                `IDX_CONV_RES_LO: rw_mask = `MASK_NONE;
                `IDX_CONV_RES_HI: rw_mask = `MASK_NONE;
                `IDX_SER_BUF: rw_mask = `MASK_NONE;
                `IDX_PA_PIN: rw_mask = `MASK_NONE;
                `IDX_PB_PIN: rw_mask = `MASK_NONE;
                `IDX_CONV_DIS_LO: rw_mask = `MASK_ALL;
                `IDX_CONV_SEL: rw_mask = `MASK_ALL;
                `IDX_SCRATCH_0: rw_mask = `MASK_ALL;
                `IDX_SCRATCH_1: rw_mask = `MASK_ALL;
                `IDX_SCRATCH_2: rw_mask = `MASK_ALL;
                `IDX_SER_CTRL: rw_mask = `MASK_ALL;
                `IDX_SER_SHIFT: rw_mask = `MASK_ALL;
                `IDX_T0_CMP_B: rw_mask = `MASK_ALL;
                `IDX_T0_CMP_A: rw_mask = `MASK_ALL;
                `IDX_T0_CNT_HI: rw_mask = `MASK_ALL;
                `IDX_PB_DIR: rw_mask = `MASK_ALL;
                `IDX_PB_OUT: rw_mask = `MASK_ALL;
                `IDX_PA_DIR: rw_mask = `MASK_ALL;
                `IDX_PA_OUT: rw_mask = `MASK_ALL;
                default: begin
                    if (i > `IO_LAST_IMPL) begin
                        rw_mask = `MASK_NONE;
                    end else begin
                        rw_mask = `MASK_ALL;
                    end
                end
            endcase
        end
    endfunction

    // Status flags cleared by writing one
    function [7:0] w1c_mask;
        input [4:0] i;
        begin
            case (i)
                `IDX_CONV_CSR_A: w1c_mask = `W1C_CONV_CSR_A;
                `IDX_CMP_CSR_A: w1c_mask = `W1C_CMP_CSR_A;
                `IDX_SER_STATUS: w1c_mask = `W1C_SER_STATUS;
                default: w1c_mask = `MASK_NONE;
            endcase
        end
    endfunction

    // Flag bits raised by the peripherals this cycle
    function [7:0] hw_set;
        input [4:0] i;
        input conv_ev;
        input cmp_ev;
        input [2:0] ser_ev;
        begin
            hw_set = `MASK_NONE;
            case (i)
                `IDX_CONV_CSR_A: hw_set[`FLAG_CONV_BIT] = conv_ev;
                `IDX_CMP_CSR_A: hw_set[`FLAG_CMP_BIT] = cmp_ev;
                `IDX_SER_STATUS: hw_set[7:5] = ser_ev;
                default: hw_set = `MASK_NONE;
            endcase
        end
    endfunction

    // Value seen by a read or a skip test, live inputs included
    function [7:0] read_value;
        input [4:0] i;
        input [8*`IO_SLOTS-1:0] img;
        input [7:0] res_lo;
        input [7:0] res_hi;
        input [7:0] ser_buf;
        input [7:0] pa;
        input [7:0] pb;
        input cmp_v;
        input coll_v;
        reg [7:0] v;
        begin
            v = img[{i, 3'h0} +: 8];
            case (i)
                `IDX_CONV_RES_LO: v = res_lo;
                `IDX_CONV_RES_HI: v = res_hi;
                `IDX_SER_BUF: v = ser_buf;
                `IDX_PA_PIN: v = pa;
                `IDX_PB_PIN: v = pb;
                `IDX_CMP_CSR_A: v[`RO_CMP_OUT_BIT] = cmp_v;
                `IDX_SER_STATUS: v[`RO_SER_COLL_BIT] = coll_v;
                default: v = img[{i, 3'h0} +: 8];
            endcase
            read_value = v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write request shaping

    always @* begin
        acc_en = 1'b0;
        acc_mask = `MASK_NONE;
        acc_data = 8'h00;
        if (do_write) begin
            acc_en = 1'b1;
            acc_mask = `MASK_ALL;
            acc_data = wdata;
        end else if (do_bit) begin // RL1
            acc_en = 1'b1;
            acc_mask = 8'h01 << bit_sel; // RL4
            if (bit_op == `OP_SET_BIT) begin
                acc_data = 8'hFF;
            end else begin
                acc_data = 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next register state

    always @* begin
        regs_nxt = regs_r;
        old_v = 8'h00;
        new_v = 8'h00;
        wm = 8'h00;
        rw_m = 8'h00;
        w1c_m = 8'h00;
        set_m = 8'h00;
        for (k = 6'h00; k < 6'h20; k = k + 6'h01) begin
            old_v = regs_r[{k[4:0], 3'h0} +: 8];
            rw_m = rw_mask(k[4:0]);
            w1c_m = w1c_mask(k[4:0]);
            set_m = hw_set(k[4:0], conv_flag_set, cmp_flag_set,
                           ser_flag_set);
            if (acc_en && (dec_idx == k[4:0])) begin
                wm = acc_mask; // RL4
            end else begin
                wm = 8'h00;
            end
            // Plain bits follow the data under the mask
            new_v = (old_v & ~(wm & rw_m)) | (acc_data & wm & rw_m);
            // Flags clear on one and hold on zero
            new_v = new_v & ~(wm & acc_data & w1c_m); // RL3
            // A new event wins over a clear in the same cycle
            new_v = new_v | set_m;
            regs_nxt[{k[4:0], 3'h0} +: 8] = new_v;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regs_r <= {`IO_SLOTS{`IO_RESET_VALUE}};
        end else begin
            regs_r <= regs_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read and skip answers

    always @* begin
        rd_val = read_value(dec_idx, regs_r, conv_result_lo,
                            conv_result_hi, ser_buffer_in, port_a_pins,
                            port_b_pins, cmp_out, ser_collision);
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_en;
            if (do_read) begin
                rd_data_r <= rd_val; // RL7
            end else if (rd_en) begin
                rd_data_r <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Skip and refusal answers

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            skip_r <= 1'b0;
            skip_valid_r <= 1'b0;
        end else begin
            skip_valid_r <= bit_op_en && is_skip;
            if (do_skip) begin
                if (bit_op == `OP_SKIP_IF_SET) begin
                    skip_r <= rd_val[bit_sel]; // RL2
                end else begin
                    skip_r <= ~rd_val[bit_sel]; // RL2
                end
            end else begin
                skip_r <= 1'b0;
            end
        end
    end

    // Bit operations beyond the low range are not carried out
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            op_refused_r <= 1'b0;
        end else begin
            op_refused_r <= bit_refused; // RL1
        end
    end

endmodule // io_register_space
